// File: ecl_pkg.sv
// ecl_pkg: shared constants for the event counter with wrap flag
// assumes: included before ecl_counter_core and ecl_event_counter
package ecl_pkg;
  localparam int unsigned       CNT_WIDTH     = 24;
  localparam logic [23:0]       CNT_MAX       = 24'hffffff;
  localparam logic [23:0]       CNT_ZERO      = 24'h000000;
  localparam logic [23:0]       CNT_ONE       = 24'h000001;
  localparam logic [2:0]        RST_CMD_CODE  = 3'h2;
  localparam logic              WRAP_RESET    = 1'h0;
  localparam int unsigned       SYNC_STAGES   = 2;
endpackage : ecl_pkg

// File: ecl_counter_core.sv
// ecl_counter_core: 24-bit wrapping up-counter with wrap toggle
// assumes: advance and clear are single-cycle, clear takes priority
`timescale 1ns/100ps
`default_nettype none
module ecl_counter_core
  import ecl_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_WIDTH
)(
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             clear,
  input  wire logic             advance,
  output logic [WIDTH-1:0]      count,
  output logic                  wrap_flag
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             wrap;
  } ecl_core_t;

  ecl_core_t state;
  ecl_core_t next_state;

  always_comb
  begin
    next_state = state;
    if (clear)
    begin
      next_state.count = '0;
      next_state.wrap  = WRAP_RESET;
    end
    else if (advance)
    begin
      next_state.count = state.count + 1'b1;
      if (&state.count)
        next_state.wrap = ~state.wrap;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= '0;
    else if (clk_en)
      state <= next_state;
  end

  assign count     = state.count;
  assign wrap_flag = state.wrap;

  wrap_toggle_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !clear && advance && (&count) |=> (count == '0)
      && (wrap_flag != $past(wrap_flag)))
    else $error("wrap flag did not toggle on rollover");

  clear_prio_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && clear |=> count == '0 && !wrap_flag)
    else $error("clear did not zero the counter");

  step_one_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !clear && advance |=> count == $past(count) + 1'b1)
    else $error("counter did not step by one");

endmodule : ecl_counter_core
`default_nettype wire

// File: ecl_event_counter.sv
// ecl_event_counter: event counter gated by serial-bus transactions
// assumes: bus start/stop detection and reset command strobe come from
// the serial framing logic outside; all inputs synchronous except
// count_input, which is synchronised here.
//
// What this block does
// - count each rising edge of count_input outside reset and transactions
// - counter is 24-bit unsigned, zero through all ones
// - an edge at all ones rolls the counter to zero
// - reset pin low or valid reset command clears the counter
// - during a transaction edges are ignored and the count holds
// - transaction window runs from start recognition to stop recognition
// - low at start and high at stop gives one catch-up count
// - first rollover after reset drives wrap_flag high
// - reset pin or reset command forces wrap_flag low
// - wrap_flag inverts on every rollover
// - count presented read-only as three bytes
// - counter held reset while reset pin low, counts once high
// - reset command only when low three free bits equal 010
// - wrap_flag low from power-on
`timescale 1ns/100ps
`default_nettype none
module ecl_event_counter
  import ecl_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_WIDTH
)(
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             count_input,
  input  wire logic             reset_n,
  input  wire logic             bus_start,
  input  wire logic             bus_stop,
  input  wire logic             free_wr,
  input  wire logic [2:0]       free_wr_low,
  output logic [WIDTH-1:0]      count_value,
  output logic                  wrap_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic                   prev;
    logic                   in_txn;
    logic                   low_at_start;
  } ecl_state_t;

  ecl_state_t state;
  ecl_state_t next_state;
  logic       clear;
  logic       advance;
  logic       cin_s;
  logic       edge_seen;
  logic       catch_up;
  logic       cmd_hit;

  assign cin_s     = state.sync[SYNC_STAGES-1];
  assign edge_seen = cin_s && !state.prev;

  assign cmd_hit = free_wr && (free_wr_low == RST_CMD_CODE);

  assign clear = !reset_n || cmd_hit;

  assign catch_up = state.in_txn && bus_stop && state.low_at_start
                    && cin_s;

  assign advance = (edge_seen && !state.in_txn && !bus_start) || catch_up;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_state.sync = {state.sync[SYNC_STAGES-2:0], count_input};
    next_state.prev = cin_s;
    if (bus_start)
    begin
      next_state.in_txn       = 1'b1;
      next_state.low_at_start = !cin_s;
    end
    else if (bus_stop)
    begin
      next_state.in_txn       = 1'b0;
      next_state.low_at_start = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= '0;
    else if (clk_en)
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // count exposed read-only; wrap low from reset
  ecl_counter_core #(
    .WIDTH     (WIDTH)
  ) u_core (
    .mclk      (mclk),
    .srst      (srst),
    .clk_en    (clk_en),
    .clear     (clear),
    .advance   (advance),
    .count     (count_value),
    .wrap_flag (wrap_flag)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // hold during window
  txn_hold_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && state.in_txn && !bus_stop && reset_n && !cmd_hit
      |=> $stable(count_value))
    else $error("count moved inside a transaction");

  pin_reset_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !reset_n |=> count_value == '0 && !wrap_flag)
    else $error("count not cleared by reset pin");

  cmd_clear_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && cmd_hit |=> count_value == '0)
    else $error("reset command did not clear");

  catch_up_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && catch_up && reset_n && !cmd_hit
      |=> count_value == $past(count_value) + 1'b1)
    else $error("missing catch-up count");

  wrap_init_a: assert property (@(posedge mclk)
    srst |=> !wrap_flag)
    else $error("wrap flag high after reset");

  // ----------------------------------------------------------------
  // window, edge, wrap and command checks
  // ----------------------------------------------------------------
  // edge counts once
  edge_step_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && edge_seen && !state.in_txn && !bus_start && reset_n
      && !cmd_hit |=> count_value == $past(count_value) + 1'b1)
    else $error("rising edge did not advance the count");

  start_edge_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && bus_start && !state.in_txn && reset_n && !cmd_hit
      |=> $stable(count_value))
    else $error("count moved at transaction start");

  win_open_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && bus_start |=> state.in_txn)
    else $error("window not opened by start");

  win_close_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && bus_stop && !bus_start |=> !state.in_txn)
    else $error("window not closed by stop");

  no_catch_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && state.in_txn && bus_stop && !(state.low_at_start && cin_s)
      && reset_n && !cmd_hit |=> $stable(count_value))
    else $error("unexpected catch-up count");

  start_level_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && bus_start |=> state.low_at_start == !$past(cin_s))
    else $error("start level not captured");

  sync_in_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en |=> state.sync[0] == $past(count_input))
    else $error("synchroniser missed the pin");

  rise_once_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && edge_seen |=> !edge_seen)
    else $error("edge seen twice");

  wrap_rise_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && advance && !clear && (&count_value) && !wrap_flag
      |=> wrap_flag)
    else $error("wrap flag did not rise on rollover");

  wrap_fall_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && advance && !clear && (&count_value) && wrap_flag
      |=> !wrap_flag)
    else $error("wrap flag did not fall on rollover");

  wrap_still_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !clear && !(advance && (&count_value))
      |=> $stable(wrap_flag))
    else $error("wrap flag moved without rollover");

  cmd_wrap_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && cmd_hit |=> !wrap_flag)
    else $error("reset command left wrap flag high");

  cmd_other_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && free_wr && free_wr_low != RST_CMD_CODE && reset_n && !advance
      |=> $stable(count_value))
    else $error("non-reset code changed the count");

  clear_edge_a: assert property (@(posedge mclk) disable iff (srst)
    clk_en && !reset_n && edge_seen |=> count_value == '0 && !wrap_flag)
    else $error("count edge beat the reset pin");

endmodule : ecl_event_counter
`default_nettype wire

// File: ecl_master_model.sv
// ecl_master_model: serial bus master framing count reads
// assumes: tasks called by the bench, signals move at falling mclk
`timescale 1ns/100ps
`default_nettype none
module ecl_master_model #(
  parameter int unsigned W = 4
)(
  input  wire logic         mclk,
  input  wire logic [W-1:0] count_value,
  output logic              bus_start,
  output logic              bus_stop
);
  initial bus_start = 1'h0;
  initial bus_stop = 1'h0;
  task automatic open_win;
    @(negedge mclk) bus_start = 1'h1;
    @(negedge mclk) bus_start = 1'h0;
  endtask : open_win
  task automatic close_win;
    @(negedge mclk) bus_stop = 1'h1;
    @(negedge mclk) bus_stop = 1'h0;
  endtask : close_win
  task automatic read3(output logic [23:0] v);
    logic [23:0] c;
    open_win();
    c = 24'(count_value);
    for (int i = 23; i >= 0; i--)
      v = {v[22:0], c[i]};
    close_win();
  endtask : read3
endmodule : ecl_master_model
`default_nettype wire

// File: event_counter_loop_flag_tb_top.sv
// bench top: event counter with a 4-bit counter to reach rollover
// assumes: ecl_pkg, ecl_event_counter and ecl_master_model compiled
`timescale 1ns/100ps
`default_nettype none
module event_counter_loop_flag_tb_top;
  typedef struct packed {
    logic [4:0] n;
    logic [3:0] c;
    logic       w;
  } ecl_row_t;
  // --------------------------------------------------
  // rows: edges applied, count and wrap expected
  // --------------------------------------------------
  localparam ecl_row_t ROWS [6] = '{'{5'h01, 4'h1, 1'h0},
    '{5'h0e, 4'hf, 1'h0}, '{5'h01, 4'h0, 1'h1}, '{5'h0f, 4'hf, 1'h1},
    '{5'h01, 4'h0, 1'h0}, '{5'h11, 4'h1, 1'h1}};
  logic mclk, srst, count_input, reset_n, free_wr, bus_start, bus_stop;
  logic        clk_en;
  logic [2:0]  free_wr_low;
  logic [3:0]  count_value, e;
  logic        wrap_flag;
  logic [23:0] rd;
  int          error_cnt = 0, checks = 0, cyc = 0;
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  ecl_event_counter #(.WIDTH(4)) dut (.mclk(mclk), .srst(srst),
    .clk_en(clk_en), .count_input(count_input), .reset_n(reset_n),
    .bus_start(bus_start), .bus_stop(bus_stop), .free_wr(free_wr),
    .free_wr_low(free_wr_low), .count_value(count_value),
    .wrap_flag(wrap_flag));
  ecl_master_model #(.W(4)) m (.mclk(mclk), .count_value(count_value),
    .bus_start(bus_start), .bus_stop(bus_stop));
  task automatic chk(input string s, input logic [23:0] x, g);
    checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic edges(input int n);
    repeat (n)
    begin
      @(negedge mclk) count_input = 1'h1;
      repeat (4) @(negedge mclk);
      count_input = 1'h0;
      repeat (4) @(negedge mclk);
    end
  endtask : edges
  task automatic cmd(input logic [2:0] v);
    @(negedge mclk) {free_wr, free_wr_low} = {1'h1, v};
    @(negedge mclk) free_wr = 1'h0;
    @(negedge mclk);
  endtask : cmd
  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    {srst, count_input, reset_n, free_wr, free_wr_low} = 7'h50;
    clk_en = 1'h1;
    repeat (5) @(negedge mclk);
    srst = 1'h0;
    chk("wrap_init", 24'h0, 24'(wrap_flag));
    foreach (ROWS[i])
    begin
      edges(ROWS[i].n);
      chk("cnt_row", 24'(ROWS[i].c), 24'(count_value));
      chk("wrap_row", 24'(ROWS[i].w), 24'(wrap_flag));
    end
    $display("rows done");
    reset_n = 1'h0;
    edges(1);
    chk("cnt_rstn", 24'h0, 24'(count_value));
    chk("wrap_rstn", 24'h0, 24'(wrap_flag));
    reset_n = 1'h1;
    edges(1);
    chk("cnt_run", 24'h1, 24'(count_value));
    $display("reset pin done");
    m.open_win();
    count_input = 1'h1;
    repeat (8) @(negedge mclk);
    chk("cnt_hold", 24'h1, 24'(count_value));
    m.close_win();
    repeat (5) @(negedge mclk);
    chk("cnt_catch", 24'h2, 24'(count_value));
    m.open_win();
    m.close_win();
    count_input = 1'h0;
    repeat (5) @(negedge mclk);
    chk("cnt_nocatch", 24'h2, 24'(count_value));
    m.read3(rd);
    chk("read3", 24'h2, rd);
    $display("window done");
    e = 4'h2;
    for (int k = 0; k < 8; k++)
    begin
      edges(1);
      e = (k == 2) ? 4'h0 : e + 4'h1;
      cmd(3'(k));
      chk("cnt_cmd", 24'(e), 24'(count_value));
    end
    $display("command done");
    clk_en = 1'h0;
    edges(1);
    clk_en = 1'h1;
    repeat (5) @(negedge mclk);
    chk("cnt_freeze", 24'(e), 24'(count_value));
    $display("freeze done");
    test_done();
  end
endmodule : event_counter_loop_flag_tb_top
`default_nettype wire
